// ---- core/conc_alarm.v ----
// one concentration alarm: enabled compare against a limit
// assumes concentration and limit share the reporting unit
`timescale 1ns/100ps
module conc_alarm #(
  parameter CONC_W = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire [CONC_W-1:0] conc_i,
  input wire [CONC_W-1:0] limit_i,
  output reg alarm_o
);

always @(posedge clk_i)
begin
  if (rst_i)
    alarm_o <= 1'b0;
  else
    alarm_o <= enable_i && (conc_i > limit_i);
end

endmodule // conc_alarm

// ---- core/pin_sync.v ----
// two-flop synchroniser for a bundle of level pins
// assumes the pins are slow levels with no timing relation to clk_i
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] level_o
);

reg [W-1:0] meta;

// first stage feeds only the second stage
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    meta <= {W{1'b0}};
    level_o <= {W{1'b0}};
  end
  else
  begin
    meta <= pin_i;
    level_o <= meta;
  end
end

endmodule // pin_sync

// ---- core/status_alarm_defines.vh ----
// Function
// - four relays exist; the fourth, spare, is never energized
// - system-ok relay energized with no fault, released on any fault
// - upper-range relay energized while ranging selects the upper range
// - zero-cal relay energized for the whole zero calibration mode
// - two independent alarms, each closes when concentration rises above its limit
// - after reset both alarms disabled, limits 100 ppm and 300 ppm
// - a change of reporting unit rescales both alarm limits
// - status bit 1 on while no fault is present
// - status bit 2 on while the measurement is valid, off otherwise
// - status bit 3 on in the upper range of dual or auto ranging
// - status bit 4 on in zero calibration, bit 5 in span calibration
// - status bit 6 on while in diagnostic mode
// - status bits 7 and 8 on while alarm one, two is enabled and concentration exceeds its limit
// - control input A enters zero calibration and shows remote-zero indication
// - control input B enters span calibration and shows remote-span indication
//
// constants of the status and alarm output block; definitions only
`ifndef STATUS_ALARM_DEFINES_VH
`define STATUS_ALARM_DEFINES_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_LIMIT_ONE 8'h04
`define REG_LIMIT_TWO 8'h08
`define REG_STATE 8'h0c
`define REG_EVENTS 8'h10
`define REG_MASK 8'h14

// control register fields
`define CTRL_CONC_ALARM_ONE_EN 0
`define CTRL_CONC_ALARM_TWO_EN 1
`define CTRL_UNIT 2
`define CTRL_SW_ZERO 3
`define CTRL_SW_SPAN 4
`define CTRL_W 5
`define CTRL_RESET 5'h00

// unit codes: 0 ppm, 1 ppb
`define UNIT_PPM 1'b0
`define UNIT_PPB 1'b1
`define UNIT_RATIO 1000

// limit reset values in ppm
`define LIMIT_ONE_RESET 100
`define LIMIT_TWO_RESET 300

// status bit positions (bit 1 of the connector is index 0)
`define ST_SYS_OK 0
`define ST_VALID 1
`define ST_HIGH 2
`define ST_ZERO 3
`define ST_SPAN 4
`define ST_DIAG 5
`define ST_CONC_ALARM_ONE 6
`define ST_CONC_ALARM_TWO 7
`define ST_W 8

// event bit positions
`define EV_FAULT 0
`define EV_CONC_ALARM_ONE 1
`define EV_CONC_ALARM_TWO 2
`define EV_RZERO 3
`define EV_RSPAN 4
`define EV_INVALID 5
`define EV_W 6
`define EV_RESET 6'h00

`endif

// ---- core/status_alarm_outputs.v ----
// status relays, isolated status bits, concentration alarms and remote
// calibration inputs, with a small register port for software
// assumes analyzer state inputs come from logic on clk_i; control pins
// are asynchronous and are synchronised here
`timescale 1ns/100ps
`include "status_alarm_defines.vh"
module status_alarm_outputs #(
  parameter CONC_W = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire fault_i,
  input wire upper_range_i,
  input wire diagnostic_flag_i,
  input wire measurement_valid_flag_i,
  input wire [CONC_W-1:0] conc_i,
  input wire ctrl_a_i,
  input wire ctrl_b_i,
  input wire [3:0] ctrl_c_to_f_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg system_ok_relay_o,
  output reg upper_range_relay_o,
  output reg zero_cal_relay_o,
  output reg spare_relay_o,
  output reg conc_alarm_one_out_o,
  output reg conc_alarm_two_out_o,
  output reg [7:0] status_bits_o,
  output reg zero_cal_mode_o,
  output reg span_cal_mode_o,
  output reg remote_zero_ind_o,
  output reg remote_span_ind_o,
  output reg irq_o
);

////////////////////////////////////////////////////////////////////////
// constants sized to what they meet

localparam [CONC_W-1:0] LIM1_RST = `LIMIT_ONE_RESET;
localparam [CONC_W-1:0] LIM2_RST = `LIMIT_TWO_RESET;
localparam [CONC_W+9:0] RATIO = `UNIT_RATIO;
localparam [CONC_W+9:0] CONC_MAX = {{10{1'b0}}, {CONC_W{1'b1}}};

////////////////////////////////////////////////////////////////////////
// software registers

reg [`CTRL_W-1:0] ctrl;
reg [CONC_W-1:0] limit_one;
reg [CONC_W-1:0] limit_two;
reg [`EV_W-1:0] events;
reg [`EV_W-1:0] mask;
reg [`ST_W-1:0] prev_status;

wire wr_ctrl;
wire wr_lim1;
wire wr_lim2;
wire wr_mask;
wire rd_events;
wire unit_change;
wire new_unit;

assign wr_ctrl = wr_i && (addr_i == `REG_CTRL);
assign wr_lim1 = wr_i && (addr_i == `REG_LIMIT_ONE);
assign wr_lim2 = wr_i && (addr_i == `REG_LIMIT_TWO);
assign wr_mask = wr_i && (addr_i == `REG_MASK);
assign rd_events = rd_i && (addr_i == `REG_EVENTS);
assign new_unit = wdata_i[`CTRL_UNIT];
assign unit_change = wr_ctrl && (new_unit != ctrl[`CTRL_UNIT]);

////////////////////////////////////////////////////////////////////////
// limit rescaling

// ppm to ppb multiplies and saturates; back again divides and truncates,
// so a round trip can lose the sub-ppm part of a limit
function [CONC_W-1:0] rescale;
  input [CONC_W-1:0] lim;
  input to_ppb;
  reg [CONC_W+9:0] wide;
  begin
    wide = {{10{1'b0}}, lim};
    if (to_ppb)
    begin
      wide = wide * RATIO;
      if (wide > CONC_MAX)
        wide = CONC_MAX;
    end
    else
      wide = wide / RATIO;
    rescale = wide[CONC_W-1:0];
  end
endfunction

reg [CONC_W-1:0] next_limit_one;
reg [CONC_W-1:0] next_limit_two;

always @*
begin
  next_limit_one = limit_one;
  next_limit_two = limit_two;
  if (unit_change)
  begin
    next_limit_one = rescale(limit_one, new_unit);
    next_limit_two = rescale(limit_two, new_unit);
  end
  if (wr_lim1)
    next_limit_one = wdata_i[CONC_W-1:0];
  if (wr_lim2)
    next_limit_two = wdata_i[CONC_W-1:0];
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    ctrl <= `CTRL_RESET;
    limit_one <= LIM1_RST;
    limit_two <= LIM2_RST;
    mask <= `EV_RESET;
  end
  else
  begin
    if (wr_ctrl)
      ctrl <= wdata_i[`CTRL_W-1:0];
    limit_one <= next_limit_one;
    limit_two <= next_limit_two;
    if (wr_mask)
      mask <= wdata_i[`EV_W-1:0];
  end
end

////////////////////////////////////////////////////////////////////////
// control pins

wire [1:0] remote_lvl;

pin_sync #(
  .W(2)
) u_pin_sync (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .pin_i({ctrl_b_i, ctrl_a_i}),
  .level_o(remote_lvl)
);

// inputs c to f unused
// ctrl_c_to_f_i is deliberately left unread so it cannot steer anything

wire remote_zero;
wire remote_span;
wire zero_mode;
wire span_mode;

assign remote_zero = remote_lvl[0];
assign remote_span = remote_lvl[1];
assign zero_mode = remote_zero || ctrl[`CTRL_SW_ZERO];
assign span_mode = remote_span || ctrl[`CTRL_SW_SPAN];

////////////////////////////////////////////////////////////////////////
// concentration alarms

wire alarm_one;
wire alarm_two;

conc_alarm #(
  .CONC_W(CONC_W)
) u_alarm_one (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .enable_i(ctrl[`CTRL_CONC_ALARM_ONE_EN]),
  .conc_i(conc_i),
  .limit_i(limit_one),
  .alarm_o(alarm_one)
);

conc_alarm #(
  .CONC_W(CONC_W)
) u_alarm_two (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .enable_i(ctrl[`CTRL_CONC_ALARM_TWO_EN]),
  .conc_i(conc_i),
  .limit_i(limit_two),
  .alarm_o(alarm_two)
);

////////////////////////////////////////////////////////////////////////
// status vector

reg [`ST_W-1:0] next_status;

always @*
begin
  next_status = {`ST_W{1'b0}};
  next_status[`ST_SYS_OK] = ~fault_i;
  next_status[`ST_VALID] = measurement_valid_flag_i;
  next_status[`ST_HIGH] = upper_range_i;
  next_status[`ST_ZERO] = zero_mode;
  next_status[`ST_SPAN] = span_mode;
  next_status[`ST_DIAG] = diagnostic_flag_i;
  next_status[`ST_CONC_ALARM_ONE] = alarm_one;
  next_status[`ST_CONC_ALARM_TWO] = alarm_two;
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    status_bits_o <= 8'h00;
    system_ok_relay_o <= 1'b0;
    upper_range_relay_o <= 1'b0;
    zero_cal_relay_o <= 1'b0;
    spare_relay_o <= 1'b0;
    conc_alarm_one_out_o <= 1'b0;
    conc_alarm_two_out_o <= 1'b0;
    zero_cal_mode_o <= 1'b0;
    span_cal_mode_o <= 1'b0;
    remote_zero_ind_o <= 1'b0;
    remote_span_ind_o <= 1'b0;
  end
  else
  begin
    status_bits_o <= next_status;
    system_ok_relay_o <= ~fault_i;
    upper_range_relay_o <= upper_range_i;
    zero_cal_relay_o <= zero_mode;
    spare_relay_o <= 1'b0;
    conc_alarm_one_out_o <= alarm_one;
    conc_alarm_two_out_o <= alarm_two;
    zero_cal_mode_o <= zero_mode;
    span_cal_mode_o <= span_mode;
    remote_zero_ind_o <= remote_zero;
    remote_span_ind_o <= remote_span;
  end
end

////////////////////////////////////////////////////////////////////////
// events and interrupt

reg [`EV_W-1:0] ev_set;
reg [`EV_W-1:0] next_events;

always @*
begin
  ev_set = {`EV_W{1'b0}};
  ev_set[`EV_FAULT] = ~next_status[`ST_SYS_OK] && prev_status[`ST_SYS_OK];
  ev_set[`EV_CONC_ALARM_ONE] = next_status[`ST_CONC_ALARM_ONE] && ~prev_status[`ST_CONC_ALARM_ONE];
  ev_set[`EV_CONC_ALARM_TWO] = next_status[`ST_CONC_ALARM_TWO] && ~prev_status[`ST_CONC_ALARM_TWO];
  ev_set[`EV_RZERO] = remote_zero && ~remote_zero_ind_o;
  ev_set[`EV_RSPAN] = remote_span && ~remote_span_ind_o;
  ev_set[`EV_INVALID] = ~next_status[`ST_VALID] && prev_status[`ST_VALID];
  // set wins over the clear of a read in the same cycle
  next_events = rd_events ? ev_set : (events | ev_set);
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    events <= `EV_RESET;
    prev_status <= 8'h00;
    irq_o <= 1'b0;
  end
  else
  begin
    events <= next_events;
    prev_status <= next_status;
    irq_o <= |(next_events & mask);
  end
end

////////////////////////////////////////////////////////////////////////
// read port

reg [31:0] next_rdata;

always @*
begin
  next_rdata = 32'h00000000;
  if (rd_i)
  begin
    case (addr_i)
      `REG_CTRL: next_rdata[`CTRL_W-1:0] = ctrl;
      `REG_LIMIT_ONE: next_rdata[CONC_W-1:0] = limit_one;
      `REG_LIMIT_TWO: next_rdata[CONC_W-1:0] = limit_two;
      `REG_STATE: next_rdata[`ST_W-1:0] = status_bits_o;
      `REG_EVENTS: next_rdata[`EV_W-1:0] = events;
      `REG_MASK: next_rdata[`EV_W-1:0] = mask;
      default: next_rdata = 32'h00000000;
    endcase
  end
end

// data stand only in the cycle after the strobe
always @(posedge clk_i)
begin
  if (rst_i)
    rdata_o <= 32'h00000000;
  else
    rdata_o <= next_rdata;
end

endmodule // status_alarm_outputs

// ---- verif/plc_model.sv ----
// controller model driving the remote control input pins
// assumes the bench hands it one request bit per pin
`timescale 1ns/100ps
module plc_model (
  input wire clk_i,
  input wire [5:0] cmd_i,
  output reg [5:0] pin_o
);
  initial pin_o = 6'h00;
  always @(posedge clk_i)
    pin_o <= cmd_i;
endmodule // plc_model

// ---- verif/sao_monitor.sv ----
// checker on the status and alarm block ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module sao_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire fault_i,
  input wire upper_range_i,
  input wire diagnostic_flag_i,
  input wire measurement_valid_flag_i,
  input wire ctrl_a_i,
  input wire ctrl_b_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire system_ok_relay_o,
  input wire upper_range_relay_o,
  input wire zero_cal_relay_o,
  input wire spare_relay_o,
  input wire conc_alarm_one_out_o,
  input wire conc_alarm_two_out_o,
  input wire [7:0] status_bits_o,
  input wire zero_cal_mode_o,
  input wire span_cal_mode_o,
  input wire remote_zero_ind_o,
  input wire remote_span_ind_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sys_ok_a: assert property (
    !$past(rst_i) |-> system_ok_relay_o == !$past(fault_i) && status_bits_o[0] == system_ok_relay_o)
    else $error("system ok output wrong");
  spare_off_a: assert property (spare_relay_o == 1'b0)
    else $error("spare relay energized");
  high_range_a: assert property (
    !$past(rst_i) |-> upper_range_relay_o == $past(upper_range_i) && status_bits_o[2] == upper_range_relay_o)
    else $error("range output wrong");
  valid_diag_a: assert property (
    !$past(rst_i) |-> status_bits_o[1] == $past(measurement_valid_flag_i)
      && status_bits_o[5] == $past(diagnostic_flag_i))
    else $error("valid or diag bit wrong");
  cal_bits_a: assert property (
    zero_cal_relay_o == zero_cal_mode_o && status_bits_o[4:3] == {span_cal_mode_o, zero_cal_mode_o})
    else $error("calibration outputs disagree");
  remote_zero_a: assert property (
    $rose(ctrl_a_i) |-> ##3 remote_zero_ind_o && zero_cal_mode_o)
    else $error("remote zero not entered");
  remote_span_a: assert property (
    $rose(ctrl_b_i) |-> ##3 remote_span_ind_o && span_cal_mode_o)
    else $error("remote span not entered");
  alarm_bits_a: assert property (
    status_bits_o[7:6] == {conc_alarm_two_out_o, conc_alarm_one_out_o})
    else $error("alarm bits disagree");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  cover property ($rose(remote_zero_ind_o));
  cover property ($rose(conc_alarm_two_out_o));
  cover property ($rose(remote_span_ind_o));
endmodule // sao_monitor
bind status_alarm_outputs sao_monitor i_sao_monitor (.*);

// ---- verif/testbench.sv ----
// self-checking bench for the status and alarm block
// assumes the design files and the controller model
`timescale 1ns/100ps
`include "status_alarm_defines.vh"
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg fault_i = 1'b0;
  reg upper_range_i = 1'b0;
  reg diagnostic_flag_i = 1'b0;
  reg measurement_valid_flag_i = 1'b0;
  reg [23:0] conc_i = 24'h0;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [5:0] cmd = 6'h00;
  reg [3:0] r;
  wire ctrl_a_i, ctrl_b_i, system_ok_relay_o, upper_range_relay_o, zero_cal_relay_o;
  wire spare_relay_o, conc_alarm_one_out_o, conc_alarm_two_out_o, zero_cal_mode_o;
  wire span_cal_mode_o, remote_zero_ind_o, remote_span_ind_o, irq_o;
  wire [3:0] ctrl_c_to_f_i;
  wire [31:0] rdata_o;
  wire [7:0] status_bits_o;
  integer error_cnt = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  always #20 clk_i = ~clk_i;
  plc_model i_plc_model (.clk_i(clk_i), .cmd_i(cmd),
    .pin_o({ctrl_c_to_f_i, ctrl_b_i, ctrl_a_i}));
  status_alarm_outputs i_status_alarm_outputs (.*);
  ////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wrt(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // m masks the bits compared
  task rdc(input [7:0] a, input [31:0] exp, input [31:0] m);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o & m, exp);
    end
  endtask
  // alarms take two edges from a concentration change
  task cc(input [23:0] c, input [1:0] e);
    begin
      @(posedge clk_i);
      conc_i <= c;
      repeat (2) @(posedge clk_i);
      #1 chk({conc_alarm_two_out_o, conc_alarm_one_out_o, status_bits_o[7:6]}, {e, e});
    end
  endtask
  // v = {diag, range, valid, fault}; cal modes and alarms off
  function [7:0] exp_st(input [3:0] v);
    exp_st = {2'b00, v[3], 2'b00, v[2], v[1], ~v[0]};
  endfunction
  // ppm to ppb saturates at the limit width
  function [31:0] up(input [31:0] x);
    up = (x * 1000 > 32'hffffff) ? 32'hffffff : x * 1000;
  endfunction
  ////////////////////////////////////////////////////////////
  initial
  begin
    i = $urandom(32'h54b8bac7);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`REG_CTRL, 0, ~0);
    rdc(`REG_LIMIT_ONE, `LIMIT_ONE_RESET, ~0);
    rdc(`REG_LIMIT_TWO, `LIMIT_TWO_RESET, ~0);
    rdc(8'h20, 0, ~0);
    $display("test reset done");
    for (i = 0; i < 24; i = i + 1)
    begin
      r = $urandom;
      @(posedge clk_i);
      {diagnostic_flag_i, upper_range_i, measurement_valid_flag_i, fault_i} <= r;
      conc_i <= $urandom;
      cmd[5:2] <= $urandom;
      @(posedge clk_i);
      #1 chk(status_bits_o, exp_st(r));
      chk({spare_relay_o, upper_range_relay_o, system_ok_relay_o}, {1'b0, r[2], ~r[0]});
    end
    $display("test status done");
    wrt(`REG_CTRL, 32'h3);
    cc(24'd100, 2'b00);
    cc(24'd101, 2'b01);
    cc(24'd301, 2'b11);
    wrt(`REG_CTRL, 32'h0);
    cc(24'd302, 2'b00);
    $display("test alarms done");
    wrt(`REG_LIMIT_TWO, 32'h123456);
    wrt(`REG_CTRL, 32'h7);
    rdc(`REG_LIMIT_ONE, up(100), ~0);
    rdc(`REG_LIMIT_TWO, up(32'h123456), ~0);
    wrt(`REG_CTRL, 32'h3);
    rdc(`REG_LIMIT_ONE, 100, ~0);
    rdc(`REG_LIMIT_TWO, 32'hffffff / 1000, ~0);
    $display("test units done");
    wrt(`REG_CTRL, 32'h0);
    rdc(`REG_EVENTS, 32'h06, 32'h06);
    wrt(`REG_MASK, 32'h08);
    @(posedge clk_i);
    cmd <= 6'h01;
    repeat (4) @(posedge clk_i);
    #1 chk({irq_o, remote_zero_ind_o, zero_cal_mode_o, zero_cal_relay_o}, 4'hf);
    rdc(`REG_EVENTS, 32'h08, 32'h18);
    @(posedge clk_i);
    #1 chk(irq_o, 0);
    @(posedge clk_i);
    cmd <= 6'h02;
    repeat (4) @(posedge clk_i);
    #1 chk({irq_o, remote_span_ind_o, span_cal_mode_o, zero_cal_mode_o}, 4'h6);
    rdc(`REG_EVENTS, 32'h10, 32'h18);
    @(posedge clk_i);
    cmd <= 6'h00;
    $display("test remote done");
    @(posedge clk_i);
    fault_i <= 1'b0;
    measurement_valid_flag_i <= 1'b1;
    upper_range_i <= 1'b0;
    diagnostic_flag_i <= 1'b0;
    // no rising edge of ok or valid may raise an event
    rdc(`REG_EVENTS, 0, ~0);
    wrt(`REG_MASK, 32'h21);
    rdc(`REG_MASK, 32'h21, ~0);
    @(posedge clk_i);
    fault_i <= 1'b1;
    measurement_valid_flag_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({irq_o, system_ok_relay_o, status_bits_o[1:0]}, 4'h8);
    rdc(`REG_EVENTS, 32'h21, ~0);
    // software zero and span modes together
    wrt(`REG_CTRL, 32'h18);
    rdc(`REG_STATE, 32'h18, ~0);
    chk({zero_cal_relay_o, zero_cal_mode_o, span_cal_mode_o, remote_zero_ind_o}, 4'he);
    wrt(`REG_CTRL, 32'h0);
    $display("test events done");
    tally_and_finish;
  end
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
endmodule // testbench
